// ### diag_pkg.sv
// package: constants for the slave diagnostic interrupt framer
package diag_pkg;
  // interrupt section layout, byte offsets from x
  localparam int HDR_LEN = 4; // header bytes x..x+3
  localparam int RI_SUPP_LEN = 5; // remove/insert supplement
  localparam int UPD_SUPP_LEN = 2; // update supplement
  localparam logic [3:0] RI_FRAME_LEN = 4'h9;
  localparam logic [3:0] UPD_FRAME_LEN = 4'h6;
  localparam logic [3:0] TYPE_BYTE_POS = 4'h1; // interrupt type byte x+1
  localparam logic [3:0] SUPP_POS = 4'h4; // first supplement byte x+4
  // interrupt type codes, values arbitrary
  localparam logic [7:0] ITYPE_REMOVE = 8'h03;
  localparam logic [7:0] ITYPE_INSERT = 8'h04;
  localparam logic [7:0] ITYPE_UPDATE = 8'h06;
  // header byte 0 length field is frame length
  // module kinds steering the identifier lookup
  localparam logic [3:0] KIND_RESERVE = 4'hD;
  localparam logic [3:0] KIND_REMOVED = 4'hE;
  localparam logic [3:0] KIND_CONFIG_IN_RUN = 4'hF; // config_in_run_reserve
  // slot range of id-related bits
  localparam int SLOT_FIRST = 4;
  localparam int SLOT_LAST = 35;
  localparam int SLOTS = 36;
  // module status codes
  localparam logic [1:0] MST_OK = 2'h0;
  localparam logic [1:0] MST_FAULT = 2'h1;
  localparam logic [1:0] MST_NONE = 2'h3;
  // state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_DONE = 3'b100
  } fr_state_type;
endpackage

// ### cfg_checker.sv
// module: invalid configuration detection and slot status
`timescale 1ns/10ps
module cfg_checker
  import diag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [SLOTS-1:0] slot_present, // module seen per slot
  input wire logic [SLOTS-1:0] slot_expected, // configured per slot
  input wire logic term_present, // terminating module seen
  input wire logic count_over, // module count above maximum
  input wire logic backplane_fault, // backplane bus fault
  input wire logic power_up, // one-cycle pulse after power cycle
  input wire logic allow_config_mismatch_operation,
  output logic cfg_invalid, // station failed
  output logic startup_ok, // data exchange may start
  output logic [SLOTS-1:0] id_diag, // id-related diagnostic bits
  output logic [2*SLOTS-1:0] mod_status // two bits per slot
);
  logic [SLOTS-1:0] missing;
  logic [6:0] miss_cnt;
  logic [5:0] fail_slot;
  logic bad_now;
  logic [SLOTS-1:0] id_nxt;
  logic [2*SLOTS-1:0] st_nxt;
  logic started_r;
  logic gap_at_pwr_r;

  assign missing = slot_expected & ~slot_present;

  // count gaps, find first failing slot
  always_comb begin
    miss_cnt = 7'h00;
    fail_slot = 6'h3F;
    for (int i = SLOTS-1; i >= 0; i--) begin
      if (missing[i]) begin
        miss_cnt = miss_cnt + 7'h01;
        fail_slot = 6'(i);
      end
    end
  end

  // mismatch setting deliberately not consulted here
  assign bad_now = (miss_cnt >= 7'h02) | ~term_present | count_over |
                   backplane_fault; // RL8 RL9

  // status images for an invalid station
  always_comb begin
    id_nxt = '0;
    st_nxt = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (bad_now && i >= SLOT_FIRST && i <= SLOT_LAST)
        id_nxt[i] = 1'b1; // RL11
      if (bad_now && 6'(i) < fail_slot)
        st_nxt[2*i +: 2] = MST_FAULT; // RL12
      else if (bad_now)
        st_nxt[2*i +: 2] = MST_NONE; // RL13
    end
  end

  // startup gate: any gap at power-up blocks until next power cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_at_pwr_r <= 1'b0;
      started_r <= 1'b0;
    end else if (power_up) begin
      gap_at_pwr_r <= |missing; // RL10
      started_r <= ~(|missing) & ~bad_now;
    end else if (bad_now) begin
      started_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_invalid <= 1'b0;
      id_diag <= '0;
      mod_status <= '0;
    end else begin
      cfg_invalid <= bad_now;
      id_diag <= id_nxt;
      mod_status <= st_nxt;
    end
  end

  // operation with a single gap only when mismatch allowed
  assign startup_ok = started_r & ~gap_at_pwr_r & ~cfg_invalid &
    (allow_config_mismatch_operation | ~(|missing));

  a_invalid_ids: assert property (@(posedge clk) disable iff (!rst_n) // RL11
    bad_now |=> cfg_invalid && id_diag[SLOT_FIRST] && id_diag[SLOT_LAST])
    else $error("id bits not set on invalid config");
  a_gap_blocks: assert property (@(posedge clk) disable iff (!rst_n) // RL10
    (power_up && |missing) |=> !startup_ok)
    else $error("startup with gap at power up");
  a_fail_any: assert property (@(posedge clk) disable iff (!rst_n) // RL8
    (backplane_fault || !term_present) |=> !startup_ok && cfg_invalid)
    else $error("station not failed");
endmodule

// ### diag_irq_framer.sv
// module: interrupt section framer for slave diagnostics
// Functional notes
// [RL1] remove/insert puts type identifier at x+4..x+8
// [RL2] byte x+1 tells removal from insertion
// [RL3] each module kind maps to fixed identifier
// [RL4] update interrupt on wrong parameter assignment
// [RL5] update interrupt on retentive data mismatch
// [RL6] update byte x+4 holds record index
// [RL7] update byte x+5 holds lost update count
// [RL8] failed station on listed invalid configurations
// [RL9] failure ignores mismatch operation setting
// [RL10] no startup with gaps after power cycle
// [RL11] invalid config sets id bits slots 4-35
// [RL12] slots before failing one report code 01
// [RL13] failing slot onward report code 11
// [RL14] remove/insert frame: 4 header, 5 supplement
// [RL15] update frame: 4 header, 2 supplement
// [RL16] header x..x+3, supplement follows gaplessly
`timescale 1ns/10ps
module diag_irq_framer
  import diag_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ri_event, // remove/insert pulse
  input wire logic ri_inserted, // 1 insert, 0 remove
  input wire logic [3:0] ri_kind, // module kind of the slot
  input wire logic [7:0] ri_slot, // slot of the event
  input wire logic param_wrong, // parameter assignment wrong
  input wire logic param_mismatch, // retentive data differs
  input wire logic [7:0] upd_index, // record index causing it
  input wire logic upd_lost, // pulse: update not delivered
  input wire logic [SLOTS-1:0] slot_present,
  input wire logic [SLOTS-1:0] slot_expected,
  input wire logic term_present,
  input wire logic count_over,
  input wire logic backplane_fault,
  input wire logic power_up,
  input wire logic allow_config_mismatch_operation,
  input wire logic byte_ready, // master takes byte
  output logic byte_valid, // byte on byte_data
  output logic [7:0] byte_data, // frame byte
  output logic [3:0] byte_pos, // offset from x
  output logic byte_last, // final byte of frame
  output logic busy, // frame in progress
  output logic cfg_invalid,
  output logic startup_ok,
  output logic [SLOTS-1:0] id_diag,
  output logic [2*SLOTS-1:0] mod_status
);
  ////////////////////////////////////////////////////////////////////
  // identifier lookup, values arbitrary
  function automatic logic [15:0] kind_id(input logic [3:0] k);
    logic [15:0] r;
    r = {12'hA10, k}; // ordinary kinds, arbitrary codes
    if (k == KIND_RESERVE) r = 16'hA1F0;
    if (k == KIND_REMOVED) r = 16'hA1F1;
    if (k == KIND_CONFIG_IN_RUN) r = 16'hA1F2;
    return r;
  endfunction

  fr_state_type state_r, state_nxt;
  logic [7:0] frame_r [0:8]; // assembled frame bytes
  logic [3:0] len_r; // frame length
  logic [3:0] pos_r, pos_nxt; // current byte
  logic upd_pend_r; // update interrupt owed
  logic upd_trig;
  logic [7:0] lost_r; // undelivered updates
  logic prev_upd_r; // edge detect of update cause
  logic start_ri, start_upd;
  logic [15:0] ident;

  ////////////////////////////////////////////////////////////////////
  // request decode and byte outputs
  assign upd_trig = (param_wrong | param_mismatch) & ~prev_upd_r; // RL4 RL5
  assign ident = kind_id(ri_kind); // RL3
  assign start_ri = (state_r == ST_IDLE) & ri_event;
  // remove/insert wins; update waits one frame
  assign start_upd = (state_r == ST_IDLE) & ~ri_event &
                     (upd_pend_r | upd_trig);
  assign byte_valid = (state_r == ST_SEND);
  assign busy = (state_r != ST_IDLE);
  assign byte_data = frame_r[pos_r];
  assign byte_pos = pos_r;
  assign byte_last = byte_valid & (pos_r == len_r - 4'h1);

  // next state: send bytes x.. in order, no gaps
  always_comb begin
    state_nxt = state_r;
    pos_nxt = pos_r;
    unique case (state_r)
      ST_IDLE: begin
        pos_nxt = 4'h0;
        if (start_ri | start_upd) state_nxt = ST_SEND;
      end
      ST_SEND: begin
        if (byte_ready) begin
          if (byte_last) state_nxt = ST_DONE;
          else pos_nxt = pos_r + 4'h1; // RL16
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
    endcase
  end

  // state and byte position registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      pos_r <= 4'h0;
      prev_upd_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r <= pos_nxt;
      prev_upd_r <= param_wrong | param_mismatch;
    end
  end

  // pending update: clear on start wins over a set in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) upd_pend_r <= 1'b0;
    else if (upd_trig & ~start_upd) upd_pend_r <= 1'b1;
    else if (start_upd) upd_pend_r <= 1'b0;
  end

  // lost update counter, reported then cleared; new loss kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lost_r <= 8'h00;
    else if (start_upd) lost_r <= {7'h00, upd_lost};
    else if (upd_lost && lost_r != 8'hFF) lost_r <= lost_r + 8'h01;
  end

  // frame assembly at start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_r <= 4'h0;
      for (int i = 0; i < 9; i++) frame_r[i] <= 8'h00;
    end else if (start_ri) begin
      len_r <= RI_FRAME_LEN; // RL14
      frame_r[0] <= {4'h0, RI_FRAME_LEN};
      frame_r[TYPE_BYTE_POS] <= // RL2
        ri_inserted ? ITYPE_INSERT : ITYPE_REMOVE;
      frame_r[2] <= ri_slot;
      frame_r[3] <= 8'h00;
      frame_r[4] <= 8'h00; // RL1
      frame_r[5] <= 8'h00;
      frame_r[6] <= 8'h00;
      frame_r[7] <= ident[15:8]; // RL1
      frame_r[8] <= ident[7:0];
    end else if (start_upd) begin
      len_r <= UPD_FRAME_LEN; // RL15
      frame_r[0] <= {4'h0, UPD_FRAME_LEN};
      frame_r[TYPE_BYTE_POS] <= ITYPE_UPDATE;
      frame_r[2] <= 8'h00;
      frame_r[3] <= 8'h00;
      frame_r[SUPP_POS] <= upd_index; // RL6
      frame_r[5] <= lost_r; // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////
  cfg_checker u_cfg (
    .clk(clk),
    .rst_n(rst_n),
    .slot_present(slot_present),
    .slot_expected(slot_expected),
    .term_present(term_present),
    .count_over(count_over),
    .backplane_fault(backplane_fault),
    .power_up(power_up),
    .allow_config_mismatch_operation(allow_config_mismatch_operation),
    .cfg_invalid(cfg_invalid),
    .startup_ok(startup_ok),
    .id_diag(id_diag),
    .mod_status(mod_status)
  );

  ////////////////////////////////////////////////////////////////////
  // frame checks: lengths, contents and byte order
  a_ri_length: assert property (@(posedge clk) disable iff (!rst_n) // RL14
    start_ri |=> len_r == RI_FRAME_LEN) else $error("bad ri length");
  a_upd_length: assert property (@(posedge clk) disable iff (!rst_n) // RL15
    start_upd |=> len_r == UPD_FRAME_LEN) else $error("bad upd length");
  a_ri_type: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    start_ri |=> frame_r[1] == ($past(ri_inserted) ? ITYPE_INSERT
    : ITYPE_REMOVE)) else $error("bad type byte");
  a_ri_ident: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    start_ri |=> {frame_r[7], frame_r[8]} == $past(ident))
    else $error("bad identifier");
  a_ri_fill: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    start_ri |=> frame_r[4] == 8'h00 && frame_r[5] == 8'h00 &&
    frame_r[6] == 8'h00) else $error("identifier field not padded");
  a_reserved_id: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    (start_ri && ri_kind == KIND_RESERVE) |=>
    {frame_r[7], frame_r[8]} == 16'hA1F0) else $error("bad reserve id");
  a_upd_header: assert property (@(posedge clk) disable iff (!rst_n) // RL15
    start_upd |=> frame_r[0] == {4'h0, UPD_FRAME_LEN} &&
    frame_r[1] == ITYPE_UPDATE) else $error("bad update header");
  a_upd_index: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    start_upd |=> frame_r[4] == $past(upd_index))
    else $error("bad record index");
  a_lost_count: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    start_upd |=> frame_r[5] == $past(lost_r))
    else $error("bad lost count");
  a_lost_sat: assert property (@(posedge clk) disable iff (!rst_n) // RL7
    (lost_r == 8'hFF && !start_upd) |=> lost_r == 8'hFF)
    else $error("lost count wrapped");
  a_ri_start: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    (start_ri || start_upd) |=> byte_valid && byte_pos == 4'h0)
    else $error("frame not started at x");
  a_byte_order: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    (byte_valid && byte_ready && !byte_last) |=>
    byte_valid && pos_r == $past(pos_r) + 4'h1)
    else $error("gap in frame");
  a_hold_byte: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    (byte_valid && !byte_ready) |=> byte_valid && $stable(pos_r))
    else $error("byte dropped before taken");
  a_frame_end: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    (byte_valid && byte_ready && byte_last) |=> !byte_valid ##1 !busy)
    else $error("frame did not end");
  a_pend_kept: assert property (@(posedge clk) disable iff (!rst_n) // RL4
    (upd_trig && busy) |=> upd_pend_r) else $error("update lost");
  a_upd_served: assert property (@(posedge clk) disable iff (!rst_n) // RL4
    (upd_trig && state_r == ST_IDLE && !ri_event) |=> busy)
    else $error("update not sent");
endmodule

// ### frame_reader.sv
// partner model: master that takes interrupt frame bytes
`timescale 1ns/10ps
module frame_reader (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall, // 1: ready comes and goes at random
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [3:0] byte_pos,
  input wire logic byte_last,
  output logic byte_ready, // level, changed only after an edge
  output logic got, // one byte was taken at the last edge
  output logic [12:0] got_word // last, pos, data of that byte
);
  // take a byte on valid and ready; a slow master drops ready at random
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_ready <= 1'h0;
      got <= 1'h0;
      got_word <= 13'h0;
    end else begin
      got <= byte_valid && byte_ready;
      got_word <= {byte_last, byte_pos, byte_data};
      byte_ready <= stall ? 1'($urandom % 2) : 1'h1;
    end
  end
endmodule

// ### test_diag_irq_framer.sv
// self-checking bench for the interrupt framer and config checks
`timescale 1ns/10ps
module test_diag_irq_framer;
  import diag_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, stall = 1'h0;
  logic ri_event = 1'h0, ri_inserted = 1'h0, param_wrong = 1'h0;
  logic param_mismatch = 1'h0, upd_lost = 1'h0, term_present = 1'h1;
  logic count_over = 1'h0, backplane_fault = 1'h0, power_up = 1'h0;
  logic allow_config_mismatch_operation = 1'h0;
  logic byte_ready, byte_valid, byte_last, busy, cfg_invalid;
  logic startup_ok, got;
  logic [3:0] ri_kind = 4'h0, byte_pos;
  logic [7:0] ri_slot = 8'h00, upd_index = 8'h00, byte_data;
  logic [SLOTS-1:0] slot_present = {SLOTS{1'h1}}, id_diag;
  logic [SLOTS-1:0] slot_expected = {SLOTS{1'h1}};
  logic [2*SLOTS-1:0] mod_status;
  logic [12:0] got_word;
  logic [12:0] exp_q[$]; // expected bytes: last, pos, data
  int err_count = 0, cmp_count = 0;

  always #25 clk = ~clk; // 20 MHz

  diag_irq_framer dut (.clk, .rst_n, .ri_event, .ri_inserted, .ri_kind,
    .ri_slot, .param_wrong, .param_mismatch, .upd_index, .upd_lost,
    .slot_present, .slot_expected, .term_present, .count_over,
    .backplane_fault, .power_up, .allow_config_mismatch_operation,
    .byte_ready, .byte_valid, .byte_data, .byte_pos, .byte_last, .busy,
    .cfg_invalid, .startup_ok, .id_diag, .mod_status);
  frame_reader reader (.clk, .rst_n, .stall, .byte_valid, .byte_data,
    .byte_pos, .byte_last, .byte_ready, .got, .got_word);

  ////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic check_byte(input logic [12:0] g, input logic [12:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: frame byte %h want %h", $time, g, e);
    end
  endtask
  task automatic check_level(input logic [71:0] g, input logic [71:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: status %h want %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // watcher: every taken byte against the oldest note
  always @(posedge clk) begin
    if (got === 1'h1) begin
      if (exp_q.size() == 0) check_byte(got_word, 13'h1FFF);
      else check_byte(got_word, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////
  // drivers
  // note n bytes, last flag on the final one
  task automatic frame(input logic [7:0] b[9], input int n);
    for (int i = 0; i < n; i++) exp_q.push_back({i == n - 1, 4'(i), b[i]});
  endtask
  // bounded wait until no frame runs and all notes are used
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((busy !== 1'h0 || exp_q.size() != 0) && n < 500);
    if (n >= 500) check_level(72'h0, 72'h1);
  endtask
  // one remove/insert event; kinds D..F use the reserved identifiers
  task automatic ri(input logic ins, input logic [3:0] k, input logic [7:0] s);
    logic [15:0] id;
    id = k >= KIND_RESERVE ? 16'hA1F0 + 16'(k - KIND_RESERVE)
      : 16'hA100 + 16'(k);
    @(posedge clk);
    ri_event <= 1'h1;
    ri_inserted <= ins;
    ri_kind <= k;
    ri_slot <= s;
    frame('{{4'h0, RI_FRAME_LEN}, ins ? ITYPE_INSERT : ITYPE_REMOVE, s,
      8'h00, 8'h00, 8'h00, 8'h00, id[15:8], id[7:0]}, 9);
    @(posedge clk);
    ri_event <= 1'h0;
    @(negedge clk) check_level(busy, 1'h1);
  endtask
  // count undelivered updates, one pulse every other cycle
  task automatic lost(input int n);
    repeat (n) begin
      @(posedge clk) upd_lost <= 1'h1;
      @(posedge clk) upd_lost <= 1'h0;
    end
  endtask
  // update request from either cause, expected lost count cnt
  task automatic upd(input logic [7:0] cnt, input logic mis);
    logic [7:0] ix;
    ix = 8'($urandom);
    @(posedge clk);
    upd_index <= ix;
    if (mis) param_mismatch <= 1'h1;
    else param_wrong <= 1'h1;
    frame('{{4'h0, UPD_FRAME_LEN}, ITYPE_UPDATE, 8'h00, 8'h00, ix, cnt,
      8'h00, 8'h00, 8'h00}, 6);
    idle();
    @(posedge clk);
    param_wrong <= 1'h0;
    param_mismatch <= 1'h0;
  endtask
  // config outputs settle one cycle after their cause; f < 0 skips status
  task automatic cfg(input logic inv, input int f);
    logic [2*SLOTS-1:0] ms;
    repeat (2) @(posedge clk);
    @(negedge clk);
    for (int s = 0; s < SLOTS; s++)
      ms[2*s+:2] = !inv ? MST_OK : s < f ? MST_FAULT : MST_NONE;
    check_level(cfg_invalid, inv);
    check_level(id_diag, {{32{inv}}, 4'h0});
    if (f >= 0) check_level(mod_status, ms);
  endtask
  // power cycle pulse, then startup permission
  task automatic pw(input logic e);
    @(posedge clk) power_up <= 1'h1;
    @(posedge clk) power_up <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk) check_level(startup_ok, e);
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int g1, g2;
    void'($urandom(76034));
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    // every module kind, both event kinds, fast then slow reader
    for (int k = 0; k < 16; k++) begin
      stall <= k[3];
      ri(k[0], 4'(k), 8'($urandom % SLOTS));
      idle();
    end
    // lost count reported, cleared, then saturated
    lost(3);
    upd(8'h03, 1'h0);
    upd(8'h00, 1'h1);
    lost(300);
    upd(8'hFF, 1'h0);
    // event mid-frame is dropped, update request waits its turn
    ri(1'h1, 4'h2, 8'h07);
    @(posedge clk);
    ri_event <= 1'h1;
    param_wrong <= 1'h1;
    @(posedge clk);
    ri_event <= 1'h0;
    upd(8'h00, 1'h0);
    // invalid configurations, with and without mismatch operation
    for (int a = 0; a < 2; a++) begin
      g1 = 4 + $urandom % 20;
      g2 = g1 + 1 + $urandom % 8;
      @(posedge clk);
      allow_config_mismatch_operation <= a[0];
      slot_present[g1] <= 1'h0;
      cfg(1'h0, 0);
      check_level(startup_ok, a[0]);
      pw(1'h0);
      slot_present[g2] <= 1'h0;
      cfg(1'h1, g1);
      for (int c = 0; c < 3; c++) begin
        @(posedge clk);
        slot_present <= {SLOTS{1'h1}};
        term_present <= c != 0;
        count_over <= c == 1;
        backplane_fault <= c == 2;
        cfg(1'h1, -1);
      end
      @(posedge clk);
      term_present <= 1'h1;
      backplane_fault <= 1'h0;
      cfg(1'h0, 0);
      pw(1'h1);
    end
    final_report();
  end

  // watchdog, well past the expected run length
  initial begin
    #2000000;
    err_count++;
    final_report();
  end
endmodule
